// File: fcc_flash_ctrl.sv
// Flash command controller: boot remap decode, flash reads, write buffer,
// command sequencer with lock regions and status, Wishbone register slave.
// Assumes a flash array macro on the fa_ ports and an SRAM that acks itself.
// Contract
// - Before remap, SRAM answers only at its own base, not at zero.
// - After remap, SRAM answers at zero and at its own base.
// - Flash always at its base; aliased at zero until remap.
// - Flash pages read as a linear array of 32-bit words.
// - A page-sized write buffer is filled through a 32-bit path.
// - Master reads come from the array; writes go to the buffer.
// - Software register interface programs read wait states and more.
// - Executes full erase, page erase, page program, lock set, lock clear.
// - Readable completion status of last command and separate error flags.
// - Enabled interrupt on command completion or on error.
// - Page program erases the target page first by itself.
// - Dual 32-bit prefetch buffer serves 16-bit reads, anticipates next word.
// - Flash split into 16 equal lock regions of 64 pages each.
// - Erase or program aimed at a locked region is refused.
// - Lock set command protects a region; lock clear command unlocks it.
// - Read wait states range from zero to three.
// - Commands without the correct key are ignored.
// - Forbidden operations raise an error flag and the interrupt.
`timescale 1ns/1ns
module fcc_flash_ctrl #(
  parameter int         PROG_CYCLES   = fcc_pkg::PROG_CYC,
  parameter int         FULL_CYCLES   = fcc_pkg::FULL_CYC,
  parameter int         PERASE_CYCLES = fcc_pkg::PERASE_CYC,
  parameter int         LOCK_CYCLES   = fcc_pkg::LOCK_CYC,
  parameter logic [7:0] CMD_KEY       = fcc_pkg::KEY_DEF
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // Register bus
  input  wire logic                        wb_cyc,
  input  wire logic                        wb_stb,
  input  wire logic                        wb_we,
  input  wire logic [7:0]                  wb_adr,
  input  wire logic [3:0]                  wb_sel,
  input  wire logic [31:0]                 wb_dat_w,
  output logic      [31:0]                 wb_dat_r,
  output logic                             wb_ack,
  // Memory bus
  input  wire logic                        mem_cyc,
  input  wire logic                        mem_stb,
  input  wire logic                        mem_we,
  input  wire logic [31:0]                 mem_adr,
  input  wire logic [3:0]                  mem_sel,
  input  wire logic [31:0]                 mem_dat_w,
  output logic      [31:0]                 mem_dat_r,
  output logic                             mem_ack,
  output logic                             sram_sel,
  // Flash array
  output logic      [fcc_pkg::WORD_AW-1:0] fa_addr,
  output logic                             fa_rd,
  input  wire logic [31:0]                 fa_rdata,
  output logic                             fa_wr,
  output logic      [31:0]                 fa_wdata,
  output logic      [fcc_pkg::PAGE_W-1:0]  fa_page,
  output logic                             fa_erase_page,
  output logic                             fa_erase_all,
  // Interrupt
  output logic                             irq
);
  import fcc_pkg::*;

  fcc_state_t          state_reg;
  logic [31:0]         timer_reg;
  logic [IDX_W-1:0]    idx_reg;
  logic [PAGE_W-1:0]   page_reg;
  logic [7:0]          op_reg;
  logic                erase_reg;
  logic                erase_all_reg;
  logic [REGIONS-1:0]  lock_reg;
  logic                remap_reg;
  logic                rdy_ie_reg;
  logic                err_ie_reg;
  logic [1:0]          ws_reg;
  logic                lock_err_reg;
  logic                key_err_reg;
  logic                irq_reg;
  logic                wb_ack_reg;
  logic [31:0]         wb_dat_r_reg;
  logic                wr_ack_reg;

  logic                idle;
  logic                done;
  logic                reg_acc;
  logic                cmd_wr;
  logic                stat_rd;
  logic [7:0]          cmd_code;
  logic [PAGE_W-1:0]   cmd_page;
  logic                key_ok;
  logic                code_ok;
  logic                locked;
  logic                cmd_go;
  logic                key_fail;
  logic                lock_fail;
  logic [11:0]         area;
  logic                low;
  logic                flash_hit;
  logic                mem_act;
  logic                pf_req;
  logic                buf_wr;
  logic                pf_ack;
  logic [31:0]         pf_data;
  logic                pf_rd;
  logic [WORD_AW-1:0]  pf_addr;
  logic [31:0]         buf_rdata;
  logic [31:0]         rd_mux;

  assign idle      = state_reg == ST_IDLE;
  assign done      = state_reg == ST_WAIT && timer_reg <= 32'h1;
  assign reg_acc   = wb_cyc && wb_stb && !wb_ack_reg;
  assign cmd_wr    = reg_acc && wb_we && wb_adr == REG_CMD;
  assign stat_rd   = reg_acc && !wb_we && wb_adr == REG_STAT;
  assign cmd_code  = wb_dat_w[CMD_CODE_LSB +: 8];
  assign cmd_page  = wb_dat_w[CMD_PAGE_LSB +: PAGE_W];
  assign key_ok    = wb_dat_w[CMD_KEY_LSB +: 8] == CMD_KEY;
  assign code_ok   = cmd_code inside {CMD_PROG, CMD_LOCK_SET, CMD_PAGE_ERASE,
                                      CMD_LOCK_CLR, CMD_FULL_ERASE};
  // Full erase touches every region, so any set lock bit blocks it
  assign locked    = (cmd_code == CMD_FULL_ERASE) ? |lock_reg :
                     (cmd_code == CMD_PROG || cmd_code == CMD_PAGE_ERASE) &&
                     lock_reg[fcc_region(cmd_page)];
  assign cmd_go    = cmd_wr && idle && key_ok && code_ok && !locked;
  assign key_fail  = cmd_wr && idle && !(key_ok && code_ok);
  assign lock_fail = cmd_wr && idle && key_ok && code_ok && locked;

  // Address decode for the boot alias
  assign area      = mem_adr[31:20];
  assign low       = area == AREA_LOW;
  assign flash_hit = area == AREA_FLASH || (low && !remap_reg);
  assign sram_sel  = mem_cyc && mem_stb &&
                     (area == AREA_SRAM || (low && remap_reg));
  assign mem_act   = mem_cyc && mem_stb && flash_hit;
  assign pf_req    = mem_act && !mem_we && idle;
  assign buf_wr    = mem_act && mem_we && idle && !wr_ack_reg;
  assign mem_ack   = pf_ack || wr_ack_reg;
  assign mem_dat_r = pf_data;

  // Array port sharing between sequencer and prefetch
  assign fa_wr         = state_reg == ST_WRITE && !erase_reg;
  assign fa_addr       = fa_wr ? {page_reg, idx_reg} : pf_addr;
  assign fa_rd         = pf_rd;
  assign fa_wdata      = buf_rdata;
  assign fa_page       = page_reg;
  assign fa_erase_page = erase_reg;
  assign fa_erase_all  = erase_all_reg;

  assign wb_ack   = wb_ack_reg;
  assign wb_dat_r = wb_dat_r_reg;
  assign irq      = irq_reg;

  fcc_pfetch #(
    .AW (WORD_AW)
  ) u_pfetch (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .en          (idle),
    .inval       (done),
    .wait_states (ws_reg),
    .rd_req      (pf_req),
    .rd_addr     (mem_adr[WORD_AW+1:2]),
    .rd_ack      (pf_ack),
    .rd_data     (pf_data),
    .fa_rd       (pf_rd),
    .fa_addr     (pf_addr),
    .fa_rdata    (fa_rdata)
  );

  fcc_wbuf #(
    .WORDS (WPP),
    .IW    (IDX_W)
  ) u_wbuf (
    .clk     (clk),
    .wr_en   (buf_wr),
    .wr_idx  (mem_adr[IDX_W+1:2]),
    .wr_sel  (mem_sel),
    .wr_data (mem_dat_w),
    .rd_idx  (idx_reg),
    .rd_data (buf_rdata)
  );

  // Command sequencer
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= ST_IDLE;
      timer_reg     <= 32'h0;
      idx_reg       <= '0;
      page_reg      <= '0;
      op_reg        <= 8'h0;
      erase_reg     <= 1'b0;
      erase_all_reg <= 1'b0;
    end else begin
      erase_reg     <= 1'b0;
      erase_all_reg <= 1'b0;
      unique case (state_reg)
        ST_IDLE: begin
          if (cmd_go) begin
            op_reg   <= cmd_code;
            page_reg <= cmd_page;
            idx_reg  <= '0;
            if (cmd_code == CMD_PROG) begin
              erase_reg <= 1'b1;
              state_reg <= ST_WRITE;
            end else if (cmd_code == CMD_PAGE_ERASE) begin
              erase_reg <= 1'b1;
              timer_reg <= 32'(PERASE_CYCLES);
              state_reg <= ST_WAIT;
            end else if (cmd_code == CMD_FULL_ERASE) begin
              erase_all_reg <= 1'b1;
              timer_reg     <= 32'(FULL_CYCLES);
              state_reg     <= ST_WAIT;
            end else begin
              timer_reg <= 32'(LOCK_CYCLES);
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WRITE: begin
          if (!erase_reg) begin
            idx_reg <= idx_reg + IDX_W'(1);
            if (idx_reg == IDX_W'(WPP - 1)) begin
              timer_reg <= 32'(PROG_CYCLES);
              state_reg <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (done) begin
            state_reg <= ST_IDLE;
          end else begin
            timer_reg <= timer_reg - 32'h1;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Lock bits, updated when a lock command finishes
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_reg <= '0;
    end else if (done && op_reg == CMD_LOCK_SET) begin
      lock_reg[fcc_region(page_reg)] <= 1'b1;
    end else if (done && op_reg == CMD_LOCK_CLR) begin
      lock_reg[fcc_region(page_reg)] <= 1'b0;
    end
  end

  // Mode and remap registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdy_ie_reg <= 1'b0;
      err_ie_reg <= 1'b0;
      ws_reg     <= WS_RST;
      remap_reg  <= 1'b0;
    end else if (reg_acc && wb_we) begin
      if (wb_adr == REG_MODE && wb_sel[0]) begin
        rdy_ie_reg <= wb_dat_w[MODE_RDY_IE];
        err_ie_reg <= wb_dat_w[MODE_ERR_IE];
      end
      if (wb_adr == REG_MODE && wb_sel[1]) begin
        ws_reg <= wb_dat_w[MODE_WS_LSB +: 2];
      end
      if (wb_adr == REG_REMAP && wb_sel[0] && wb_dat_w[0]) begin
        remap_reg <= 1'b1;
      end
    end
  end

  // Sticky error flags; a new error wins over the clear by status read
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_err_reg <= 1'b0;
      key_err_reg  <= 1'b0;
    end else begin
      lock_err_reg <= lock_fail || (lock_err_reg && !stat_rd);
      key_err_reg  <= key_fail || (key_err_reg && !stat_rd);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= (idle && rdy_ie_reg) ||
                 ((lock_err_reg || key_err_reg) && err_ie_reg);
    end
  end

  // Register read data
  always_comb begin
    rd_mux = 32'h0;
    unique case (wb_adr)
      REG_MODE: begin
        rd_mux[MODE_RDY_IE]        = rdy_ie_reg;
        rd_mux[MODE_ERR_IE]        = err_ie_reg;
        rd_mux[MODE_WS_LSB +: 2]   = ws_reg;
      end
      REG_STAT: begin
        rd_mux[ST_READY]    = idle;
        rd_mux[ST_LOCK_ERR] = lock_err_reg;
        rd_mux[ST_KEY_ERR]  = key_err_reg;
      end
      REG_LOCK:  rd_mux[REGIONS-1:0] = lock_reg;
      REG_REMAP: rd_mux[0]           = remap_reg;
      default:   rd_mux              = 32'h0;
    endcase
  end

  // Bus answers: one cycle after each request
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_reg   <= 1'b0;
      wb_dat_r_reg <= 32'h0;
      wr_ack_reg   <= 1'b0;
    end else begin
      wb_ack_reg <= reg_acc;
      wr_ack_reg <= buf_wr;
      if (reg_acc && !wb_we) begin
        wb_dat_r_reg <= rd_mux;
      end
    end
  end

  property p_sram_boot;
    @(posedge clk) disable iff (sys_rst)
    (mem_cyc && mem_stb && low && !remap_reg) |-> !sram_sel && flash_hit;
  endproperty
  a_sram_boot: assert property (p_sram_boot) else $error("SRAM decoded at zero");

  property p_sram_remap;
    @(posedge clk) disable iff (sys_rst)
    (mem_cyc && mem_stb && low && remap_reg) |-> sram_sel && !flash_hit;
  endproperty
  a_sram_remap: assert property (p_sram_remap) else $error("SRAM missing at zero");

  property p_flash_base;
    @(posedge clk) disable iff (sys_rst)
    (mem_cyc && mem_stb && area == AREA_FLASH) |-> flash_hit && !sram_sel;
  endproperty
  a_flash_base: assert property (p_flash_base) else $error("Flash base not decoded");

  property p_remap_hold;
    @(posedge clk) disable iff (sys_rst)
    remap_reg |=> remap_reg;
  endproperty
  a_remap_hold: assert property (p_remap_hold) else $error("Remap flag fell");

  property p_auto_erase;
    @(posedge clk) disable iff (sys_rst)
    (cmd_go && cmd_code == CMD_PROG) |=> fa_erase_page && !fa_wr ##1 fa_wr ##63 fa_wr
      ##1 !fa_wr && state_reg == ST_WAIT;
  endproperty
  a_auto_erase: assert property (p_auto_erase) else $error("Program sequence wrong");

  property p_lock_refuse;
    @(posedge clk) disable iff (sys_rst)
    lock_fail |=> lock_err_reg && idle && !fa_erase_page && !fa_erase_all;
  endproperty
  a_lock_refuse: assert property (p_lock_refuse) else $error("Locked target accepted");

  property p_key_refuse;
    @(posedge clk) disable iff (sys_rst)
    key_fail |=> key_err_reg && idle && $stable(lock_reg);
  endproperty
  a_key_refuse: assert property (p_key_refuse) else $error("Keyless command ran");

  property p_busy_hold;
    @(posedge clk) disable iff (sys_rst)
    (cmd_wr && state_reg == ST_WAIT && timer_reg > 32'h1) |=>
      state_reg == ST_WAIT && $stable(op_reg) && $stable(page_reg);
  endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("Command taken while busy");

  property p_lock_set;
    @(posedge clk) disable iff (sys_rst)
    (done && op_reg == CMD_LOCK_SET) |=> lock_reg[fcc_region(page_reg)] && idle;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("Lock bit not set");

  property p_err_irq;
    @(posedge clk) disable iff (sys_rst)
    ((lock_fail || key_fail) && err_ie_reg) |=> ##1 irq;
  endproperty
  a_err_irq: assert property (p_err_irq) else $error("Error interrupt missing");

endmodule

// File: fcc_pkg.sv
// Shared constants, field layout and types of the flash command controller
// Assumes a 250 MHz clock; times are in ns and turned into cycle counts here
package fcc_pkg;

  // Timing
  localparam int CLK_NS     = 4;
  localparam int PROG_NS    = 4000000;
  localparam int FULL_NS    = 10000000;
  localparam int PERASE_NS  = 2000000;
  localparam int LOCK_NS    = 1000;
  localparam int PROG_CYC   = (PROG_NS + CLK_NS - 1) / CLK_NS;
  localparam int FULL_CYC   = (FULL_NS + CLK_NS - 1) / CLK_NS;
  localparam int PERASE_CYC = (PERASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOCK_CYC   = (LOCK_NS + CLK_NS - 1) / CLK_NS;

  // Array geometry
  localparam int WORD_AW     = 16;
  localparam int PAGE_W      = 10;
  localparam int IDX_W       = 6;
  localparam int WPP         = 64;
  localparam int REGIONS     = 16;
  localparam int REGION_LSB  = 6;

  // Memory map areas, selected by address bits 31:20
  localparam logic [11:0] AREA_LOW   = 12'h000;
  localparam logic [11:0] AREA_FLASH = 12'h001;
  localparam logic [11:0] AREA_SRAM  = 12'h002;

  // Register offsets
  localparam logic [7:0] REG_MODE  = 8'h00;
  localparam logic [7:0] REG_CMD   = 8'h04;
  localparam logic [7:0] REG_STAT  = 8'h08;
  localparam logic [7:0] REG_LOCK  = 8'h0C;
  localparam logic [7:0] REG_REMAP = 8'h10;

  // Field positions
  localparam int MODE_RDY_IE  = 0;
  localparam int MODE_ERR_IE  = 1;
  localparam int MODE_WS_LSB  = 8;
  localparam int CMD_CODE_LSB = 0;
  localparam int CMD_PAGE_LSB = 8;
  localparam int CMD_KEY_LSB  = 24;
  localparam int ST_READY     = 0;
  localparam int ST_LOCK_ERR  = 1;
  localparam int ST_KEY_ERR   = 2;

  // Reset values
  localparam logic [1:0] WS_RST = 2'h0;

  // Command codes and key (key value arbitrary)
  localparam logic [7:0] CMD_PROG       = 8'h01;
  localparam logic [7:0] CMD_LOCK_SET   = 8'h02;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h03;
  localparam logic [7:0] CMD_LOCK_CLR   = 8'h04;
  localparam logic [7:0] CMD_FULL_ERASE = 8'h08;
  localparam logic [7:0] KEY_DEF        = 8'h5A;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_WRITE = 3'h2,
    ST_WAIT  = 3'h4
  } fcc_state_t;

  function automatic logic [3:0] fcc_region(input logic [PAGE_W-1:0] pg);
    return pg[PAGE_W-1:REGION_LSB];
  endfunction

endpackage

// File: fcc_wbuf.sv
// Page write buffer: byte-lane writes from masters, word reads by the sequencer
// Assumes writes and reads never need a defined initial content
`timescale 1ns/1ns
module fcc_wbuf #(
  parameter int WORDS = fcc_pkg::WPP,
  parameter int IW    = fcc_pkg::IDX_W
) (
  // Clock
  input  wire logic          clk,
  // Write side
  input  wire logic          wr_en,
  input  wire logic [IW-1:0] wr_idx,
  input  wire logic [3:0]    wr_sel,
  input  wire logic [31:0]   wr_data,
  // Read side
  input  wire logic [IW-1:0] rd_idx,
  output logic      [31:0]   rd_data
);
  import fcc_pkg::*;

  logic [31:0] mem [WORDS];

  genvar b;
  generate
    for (b = 0; b < 4; b++) begin : g_lane
      always_ff @(posedge clk) begin
        if (wr_en && wr_sel[b]) begin
          mem[wr_idx][8*b +: 8] <= wr_data[8*b +: 8];
        end
      end
    end
  endgenerate

  assign rd_data = mem[rd_idx];

endmodule

// File: fcc_pfetch.sv
// Dual-word prefetch buffer in front of the flash array read port
// Assumes the array latches fa_addr on fa_rd and holds fa_rdata one cycle later
`timescale 1ns/1ns
module fcc_pfetch #(
  parameter int AW = fcc_pkg::WORD_AW
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // Control
  input  wire logic          en,
  input  wire logic          inval,
  input  wire logic [1:0]    wait_states,
  // Read request
  input  wire logic          rd_req,
  input  wire logic [AW-1:0] rd_addr,
  output logic               rd_ack,
  output logic      [31:0]   rd_data,
  // Array read port
  output logic               fa_rd,
  output logic      [AW-1:0] fa_addr,
  input  wire logic [31:0]   fa_rdata
);
  import fcc_pkg::*;

  logic [AW-1:0] tag_reg [2];
  logic [31:0]   dat_reg [2];
  logic [1:0]    val_reg;
  logic          busy_reg;
  logic          demand_reg;
  logic [1:0]    cnt_reg;
  logic [AW-1:0] fetch_reg;
  logic [AW-1:0] last_reg;
  logic          nxt_reg;
  logic          ack_reg;
  logic [31:0]   data_reg;
  logic [AW-1:0] nxt_addr;
  logic          hit;
  logic          nxt_hit;
  logic          start_miss;
  logic          start_pf;

  // Slot chosen by word parity, so a word and its successor share the pair
  assign nxt_addr   = last_reg + AW'(1);
  assign hit        = val_reg[rd_addr[0]] && tag_reg[rd_addr[0]] == rd_addr;
  assign nxt_hit    = val_reg[nxt_addr[0]] && tag_reg[nxt_addr[0]] == nxt_addr;
  assign start_miss = en && !busy_reg && rd_req && !hit;
  assign start_pf   = en && !busy_reg && !rd_req && nxt_reg && !nxt_hit;
  assign fa_rd      = start_miss || start_pf;
  assign fa_addr    = busy_reg ? fetch_reg : (start_miss ? rd_addr : nxt_addr);
  assign rd_ack     = ack_reg;
  assign rd_data    = data_reg;

  // Fetch sequencing with programmable wait states
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg   <= 1'b0;
      demand_reg <= 1'b0;
      cnt_reg    <= 2'h0;
      fetch_reg  <= '0;
      last_reg   <= '0;
      nxt_reg    <= 1'b0;
      val_reg    <= 2'h0;
      tag_reg[0] <= '0;
      tag_reg[1] <= '0;
      dat_reg[0] <= 32'h0;
      dat_reg[1] <= 32'h0;
    end else if (inval) begin
      busy_reg <= 1'b0;
      nxt_reg  <= 1'b0;
      val_reg  <= 2'h0;
    end else if (busy_reg) begin
      if (cnt_reg == 2'h0) begin
        busy_reg                <= 1'b0;
        val_reg[fetch_reg[0]]   <= 1'b1;
        tag_reg[fetch_reg[0]]   <= fetch_reg;
        dat_reg[fetch_reg[0]]   <= fa_rdata;
        last_reg                <= fetch_reg;
        nxt_reg                 <= demand_reg;
      end else begin
        cnt_reg <= cnt_reg - 2'h1;
      end
    end else if (fa_rd) begin
      busy_reg   <= 1'b1;
      demand_reg <= start_miss;
      cnt_reg    <= wait_states;
      fetch_reg  <= fa_addr;
    end else if (rd_req && hit && !ack_reg) begin
      last_reg <= rd_addr;
      nxt_reg  <= 1'b1;
    end
  end

  // Answer from the buffer, so both halves of a word hit without a new fetch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_reg  <= 1'b0;
      data_reg <= 32'h0;
    end else begin
      ack_reg <= rd_req && hit && !ack_reg && !inval;
      if (rd_req && hit && !ack_reg) begin
        data_reg <= dat_reg[rd_addr[0]];
      end
    end
  end

endmodule

// File: fcc_array_model.sv
// Flash array model: answers a latch strobe with word data one cycle later
// Assumes one clock; content is a fixed pattern of the word address
`timescale 1ns/1ns
module fcc_array_model (
  // Clock
  input  wire logic        clk,
  // Array read port
  input  wire logic        fa_rd,
  input  wire logic [15:0] fa_addr,
  output logic      [31:0] fa_rdata
);
  // Word data held until the next strobe
  always_ff @(posedge clk) begin
    if (fa_rd) begin
      fa_rdata <= {16'hC3A5, fa_addr};
    end
  end
endmodule

// File: tb.sv
// Testbench: register and memory bus sequences against the flash controller
// Assumes the array model on the fa_ ports and shortened command times
`timescale 1ns/1ns
module tb;
  import fcc_pkg::*;
  logic        clk = '0, sys_rst = '1, wb_cyc = '0, wb_stb = '0, wb_we = '0;
  logic        mem_cyc = '0, mem_stb = '0, mem_we = '0;
  logic [7:0]  wb_adr = '0;
  logic [3:0]  wb_sel = 4'hF, mem_sel = 4'hF;
  logic [31:0] wb_dat_w = '0, mem_dat_w = '0, mem_adr = '0, rd, wd0;
  logic [31:0] wb_dat_r, mem_dat_r, fa_rdata, fa_wdata;
  logic        wb_ack, mem_ack, sram_sel, fa_rd, fa_wr, fa_erase_page, fa_erase_all, irq;
  logic [15:0] fa_addr;
  logic [9:0]  fa_page;
  logic [7:0]  codes [3] = '{CMD_PAGE_ERASE, CMD_PROG, CMD_FULL_ERASE};
  int          failures = 0, checks = 0, nw = 0, ne = 0, na = 0, n;

  fcc_flash_ctrl #(.PROG_CYCLES(20), .FULL_CYCLES(30), .PERASE_CYCLES(10),
    .LOCK_CYCLES(5)) dut_u (.clk, .sys_rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr,
    .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .mem_cyc, .mem_stb, .mem_we, .mem_adr,
    .mem_sel, .mem_dat_w, .mem_dat_r, .mem_ack, .sram_sel, .fa_addr, .fa_rd,
    .fa_rdata, .fa_wr, .fa_wdata, .fa_page, .fa_erase_page, .fa_erase_all, .irq);
  fcc_array_model arr_u (.clk, .fa_rd, .fa_addr, .fa_rdata);

  always #2 clk = ~clk;

  // Counts array writes and erase pulses
  always @(posedge clk) begin
    if (fa_wr === 1'b1) begin
      if (nw == 0) wd0 = fa_wdata;
      nw++;
    end
    ne += (fa_erase_page === 1'b1);
    na += (fa_erase_all === 1'b1);
  end

  task automatic final_report();
    $display("checks=%0d failures=%0d", checks, failures);
    if (failures == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc <= '1;
    wb_stb <= '1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (wb_ack !== 1'b1 && n < 99);
    rd = wb_dat_r;
    wb_cyc <= '0;
    wb_stb <= '0;
    if (n >= 99) begin failures++; final_report(); end
    @(posedge clk);
  endtask

  task automatic mb(input logic we, input logic [31:0] a, input logic [31:0] d);
    mem_cyc <= '1;
    mem_stb <= '1;
    mem_we <= we;
    mem_adr <= a;
    mem_dat_w <= d;
    n = 0;
    do begin @(posedge clk); n++; end while (mem_ack !== 1'b1 && n < 99);
    rd = mem_dat_r;
    mem_cyc <= '0;
    mem_stb <= '0;
    if (n >= 99) begin failures++; final_report(); end
    @(posedge clk);
  endtask

  task automatic probe(input logic [31:0] a, input logic e);
    mem_cyc <= '1;
    mem_stb <= '1;
    mem_we <= '0;
    mem_adr <= a;
    @(negedge clk) chk(sram_sel, e);
    @(posedge clk) mem_cyc <= '0;
    mem_stb <= '0;
    @(posedge clk);
  endtask

  task automatic wait_rdy();
    repeat (60) begin wb('0, REG_STAT, '0); if (rd[0] === 1'b1) return; end
    failures++;
    final_report();
  endtask

  function automatic logic [31:0] cw(logic [7:0] c, logic [9:0] p, logic [7:0] k);
    return {k, 6'h00, p, c};
  endfunction

  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= '0;
    @(posedge clk);
    wb('0, REG_STAT, '0);
    chk(rd, 32'h1);
    wb('0, REG_LOCK, '0);
    chk(rd, '0);
    wb('0, REG_REMAP, '0);
    chk(rd, '0);
    wb('0, 8'h40, '0);
    chk(rd, '0);
    wb('1, REG_MODE, 32'h302);
    wb('0, REG_MODE, '0);
    chk(rd, 32'h302);
    mb('0, 32'h0010_0100, '0);
    chk(32'(n), 32'h7);
    chk(rd, 32'hC3A5_0040);
    mb('0, 32'h0000_000C, '0);
    chk(rd, 32'hC3A5_0003);
    mb('0, 32'h0000_000E, '0);
    chk(32'(n), 32'h2);
    mb('0, 32'h0010_0010, '0);
    chk(rd, 32'hC3A5_0004);
    mb('1, 32'h0010_0000, 32'h1234_ABCD);
    mem_sel <= 4'h1;
    mb('1, 32'h0010_0000, 32'h5555_55EE);
    chk(32'(nw), '0);
    wb('1, REG_CMD, cw(CMD_PROG, 10'h000, KEY_DEF));
    wb('0, REG_STAT, '0);
    chk(rd, '0);
    wait_rdy();
    chk(32'(nw), 32'h40);
    chk(wd0, 32'h1234_ABEE);
    chk(32'(ne), 32'h1);
    wb('1, REG_CMD, cw(CMD_LOCK_SET, 10'h07F, KEY_DEF));
    wait_rdy();
    wb('0, REG_LOCK, '0);
    chk(rd, 32'h2);
    foreach (codes[i]) begin
      wb('1, REG_CMD, cw(codes[i], 10'h040, KEY_DEF));
      repeat (2) @(posedge clk);
      chk(irq, 32'h1);
      wb('0, REG_STAT, '0);
      chk(rd, 32'h3);
    end
    repeat (2) @(posedge clk);
    chk(irq, '0);
    wb('1, REG_CMD, cw(CMD_LOCK_CLR, 10'h040, 8'hA5));
    wb('0, REG_STAT, '0);
    chk(rd, 32'h5);
    wb('1, REG_CMD, cw(CMD_LOCK_CLR, 10'h040, KEY_DEF));
    wait_rdy();
    wb('0, REG_LOCK, '0);
    chk(rd, '0);
    wb('1, REG_CMD, cw(CMD_PAGE_ERASE, 10'h040, KEY_DEF));
    wb('1, REG_CMD, cw(CMD_LOCK_SET, 10'h000, KEY_DEF));
    wait_rdy();
    chk(rd, 32'h1);
    chk(32'(ne), 32'h2);
    wb('0, REG_LOCK, '0);
    chk(rd, '0);
    wb('1, REG_CMD, cw(CMD_FULL_ERASE, 10'h000, KEY_DEF));
    wait_rdy();
    chk(32'(na), 32'h1);
    wb('1, REG_MODE, 32'h1);
    chk(irq, 32'h1);
    wb('1, REG_CMD, cw(CMD_LOCK_CLR, 10'h000, KEY_DEF));
    chk(irq, '0);
    wait_rdy();
    chk(irq, 32'h1);
    probe(32'h0020_0000, '1);
    wb('1, REG_REMAP, 32'h1);
    wb('0, REG_REMAP, '0);
    chk(rd, 32'h1);
    probe(32'h0000_0000, '1);
    sys_rst <= '1;
    repeat (2) @(posedge clk);
    sys_rst <= '0;
    @(posedge clk);
    wb('0, REG_REMAP, '0);
    chk(rd, '0);
    probe(32'h0000_0000, '0);
    mb('0, 32'h0010_0020, '0);
    chk(rd, 32'hC3A5_0008);
    final_report();
  end
endmodule
